// *** psf_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "psf_consts.svh"
// Notes on behaviour
// - driver A must be off at stroke start
// - drivers A,B not on or shorted: 71
// - valve control flip-flop check fails: 72
// - missing-pulse window misbehaves: 73
// - both valve relays closed at start
// - both valve relays opened at end
// - lockout driver must turn on: 76
// - lockout check contacts closed before energize
// - rotation must begin within start limit
// - overrun on during 20 degree dwell: 81
// - more than one overrun cycle: 85
// - overrun not closed or closed at 180
// - option switch window versus top angle: 89
// - valve monitor fault 47, reset then off
module psf_monitor import psf_pkg::*; #(
    parameter int unsigned SETTLE_CYC = `PSF_SETTLE_US * `PSF_CLK_MHZ,
    parameter int unsigned MS_CYC = `PSF_MS_US * `PSF_CLK_MHZ
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // operator inputs
    input wire logic stroke_req,
    input wire logic selector_off,
    input wire logic reset_btn,
    // valve and lockout feedback
    input wire logic drv_a_fb,
    input wire logic drv_b_fb,
    input wire logic ctl_ff_fb,
    input wire logic mpd_window,
    input wire logic relay_a_closed,
    input wire logic relay_b_closed,
    input wire logic lock_drv_fb,
    input wire logic lock_check_closed,
    input wire logic dual_safety_valve_ok,
    // crank sensing
    input wire logic overrun_sw,
    input wire logic [1:0] option_sw,
    input wire logic [8:0] angle,
    // outputs
    output logic valve_on,
    output logic lockout_on,
    output logic fault_active,
    output logic [6:0] fault_code,
    output logic irq
);
    // ==========================================
    // pin synchronisers
    localparam int PW = 24;
    psf_sync_if #(.W(PW)) pins ();
    // valve monitor goes in inverted: a cleared stage must read healthy,
    // otherwise every reset would latch a false valve fault
    assign pins.raw = {stroke_req, selector_off, reset_btn, drv_a_fb,
        drv_b_fb, ctl_ff_fb, mpd_window, relay_a_closed, relay_b_closed,
        lock_drv_fb, lock_check_closed, !dual_safety_valve_ok, overrun_sw,
        option_sw, angle};
    psf_sync #(.W(PW)) u_sync (
        .clk(clk),
        .rst(rst),
        .p(pins.sync_side)
    );
    // synchronised copies
    logic s_req, s_off, s_rbtn, s_da, s_db, s_ff, s_mpd, s_ra, s_rb;
    logic s_ld, s_lc, s_vf, s_vm, s_ov;
    logic [1:0] s_opt;
    logic [8:0] s_ang;
    // resolver word assumed to change by one step per update
    assign {s_req, s_off, s_rbtn, s_da, s_db, s_ff, s_mpd, s_ra, s_rb,
        s_ld, s_lc, s_vf, s_ov, s_opt, s_ang} = pins.sync;
    assign s_vm = !s_vf;

    // ==========================================
    // state
    typedef struct packed {
        psf_state_t st;
        logic [31:0] cnt;      // settle and ms prescale
        logic [7:0] ms;        // elapsed ms since run began, holds at 255
        logic moved;           // rotation seen this stroke
        logic [8:0] ang0;      // angle when run began
        logic [8:0] pang;      // previous angle
        logic pov;             // previous overrun level
        logic prbtn;           // previous reset button level
        logic [1:0] ovn;       // overrun closures this stroke
        logic f47_arm;         // reset pressed, waiting for off
        logic [6:0] code;      // latched fault, zero when clear
        logic valve;
        logic lock;
        logic [1:0] stat;      // sticky interrupt events
        logic [1:0] mask;
        logic [8:0] top;       // top-stop on angle
        logic [7:0] lim;       // start-time limit in ms
        logic [31:0] rdata;
    } psf_mon_t;
    psf_mon_t q;
    psf_mon_t next_q;

    // first fault wins, later ones keep the earlier code
    function automatic logic [6:0] pick(input logic [6:0] cur,
        input logic cond, input logic [6:0] code);
        pick = (cur != 7'h00) ? cur : (cond ? code : 7'h00);
    endfunction : pick

    // low edge of the angle window chosen by the option switches
    function automatic logic [9:0] win_lo(input logic [1:0] sw);
        win_lo = `PSF_WIN_BASE + 10'(sw) * `PSF_WIN_STEP;
    endfunction : win_lo

    logic settled, ms_tick, bad_cfg, in_dwell, ov_rise, cross_mid;
    logic rst_press, acc, wr, mapped;
    logic [6:0] f;
    logic [9:0] lo;
    assign settled = q.cnt >= 32'(SETTLE_CYC - 1);
    assign ms_tick = q.cnt >= 32'(MS_CYC - 1);
    assign lo = win_lo(s_opt);
    // top angle must fall inside the selected window
    assign bad_cfg = ({1'b0, q.top} < lo)
        || ({1'b0, q.top} > lo + `PSF_WIN_SPAN);
    // top-stop timing active for the dwell after the on angle
    assign in_dwell = ({1'b0, s_ang} >= {1'b0, q.top})
        && ({1'b0, s_ang} < {1'b0, q.top} + `PSF_DWELL_DEG);
    assign ov_rise = s_ov && !q.pov;
    assign cross_mid = (q.pang < `PSF_MID_DEG) && (s_ang >= `PSF_MID_DEG);
    assign rst_press = s_rbtn && !q.prbtn;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign mapped = (paddr == `PSF_REG_CFG) || (paddr == `PSF_REG_FAULT)
        || (paddr == `PSF_REG_ISTAT) || (paddr == `PSF_REG_IMASK);

    // ==========================================
    // next state
    always_comb begin
        next_q = q;
        f = 7'h00;
        next_q.pang = s_ang;
        next_q.pov = s_ov;
        next_q.prbtn = s_rbtn;
        next_q.cnt = q.cnt + 32'd1;
        // valve monitor may fault at any time
        f = pick(f, !s_vm, `PSF_F47);
        case (q.st)
            PSF_IDLE: begin
                next_q.valve = 1'b0;
                next_q.lock = 1'b0;
                // driver B on while idle means a short
                f = pick(f, s_db, `PSF_F71);
                if (s_req && q.code == 7'h00 && s_vm) begin
                    f = pick(f, bad_cfg, `PSF_F89);
                    if (f == 7'h00) begin
                        next_q.st = PSF_PRECHK;
                    end
                end
            end
            PSF_PRECHK: begin
                f = pick(f, s_da, `PSF_F70);
                f = pick(f, !s_lc, `PSF_F77);
                if (f == 7'h00) begin
                    next_q.lock = 1'b1;
                    next_q.cnt = 32'd0;
                    next_q.st = PSF_LOCKON;
                end
            end
            PSF_LOCKON: begin
                if (settled) begin
                    f = pick(f, !s_ld, `PSF_F76);
                    next_q.valve = 1'b1;
                    next_q.cnt = 32'd0;
                    next_q.st = PSF_ENERGIZE;
                end
            end
            PSF_ENERGIZE: begin
                if (settled) begin
                    f = pick(f, !(s_da && s_db), `PSF_F71);
                    f = pick(f, !s_ff, `PSF_F72);
                    f = pick(f, !s_mpd, `PSF_F73);
                    f = pick(f, !(s_ra && s_rb), `PSF_F74);
                    next_q.cnt = 32'd0;
                    next_q.ms = 8'h00;
                    next_q.moved = 1'b0;
                    next_q.ovn = 2'b00;
                    next_q.ang0 = s_ang;
                    next_q.st = PSF_RUN;
                end
            end
            PSF_RUN: begin
                if (ms_tick) begin
                    next_q.cnt = 32'd0;
                    if (q.ms != 8'hff) begin
                        next_q.ms = q.ms + 8'h01;
                    end
                end
                if (s_ang != q.ang0) begin
                    next_q.moved = 1'b1;
                end
                // no motion within the limit
                f = pick(f, !q.moved && q.ms >= q.lim, `PSF_F79);
                f = pick(f, ov_rise && in_dwell, `PSF_F81);
                if (ov_rise && q.ovn != 2'b11) begin
                    next_q.ovn = q.ovn + 2'b01;
                end
                // a second closure in one stroke
                f = pick(f, ov_rise && q.ovn != 2'b00, `PSF_F85);
                f = pick(f, cross_mid && s_ov, `PSF_F88);
                // stop at the top-stop on angle after rotating
                if (q.moved && s_ang == q.top) begin
                    next_q.valve = 1'b0;
                    next_q.cnt = 32'd0;
                    next_q.st = PSF_STOPCHK;
                end
            end
            PSF_STOPCHK: begin
                f = pick(f, ov_rise && in_dwell, `PSF_F81);
                if (settled) begin
                    f = pick(f, s_ra || s_rb, `PSF_F75);
                    f = pick(f, s_ff, `PSF_F72);
                    f = pick(f, s_mpd, `PSF_F73);
                    f = pick(f, q.ovn == 2'b00, `PSF_F88);
                    next_q.lock = 1'b0;
                    next_q.st = PSF_IDLE;
                    next_q.stat[`PSF_IST_DONE] = 1'b1;
                end
            end
            default: begin
                next_q.st = PSF_IDLE;
            end
        endcase
        // fault clear: reset press; 89 and 77 also need their condition gone
        if (q.code != 7'h00 && rst_press) begin
            if (q.code == `PSF_F47) begin
                next_q.f47_arm = 1'b1;
            end else if (!(q.code == `PSF_F89 && bad_cfg)
                && !(q.code == `PSF_F77 && !s_lc)) begin
                next_q.code = 7'h00;
            end
        end
        // 47 needs the selector through off after reset
        if (q.code == `PSF_F47 && q.f47_arm && s_off && s_vm) begin
            next_q.code = 7'h00;
            next_q.f47_arm = 1'b0;
        end
        // apb writes; hardware set wins over w1c below
        if (wr && paddr == `PSF_REG_CFG) begin
            next_q.top = pwdata[8:0];
            next_q.lim = pwdata[`PSF_CFG_LIM_LSB +: 8];
        end
        if (wr && paddr == `PSF_REG_IMASK) begin
            next_q.mask = pwdata[1:0];
        end
        if (wr && paddr == `PSF_REG_ISTAT) begin
            next_q.stat = q.stat & ~pwdata[1:0];
            if (q.st == PSF_STOPCHK && next_q.st == PSF_IDLE) begin
                next_q.stat[`PSF_IST_DONE] = 1'b1;
            end
        end
        // latch a new fault and drop outputs safe
        if (f != 7'h00) begin
            if (q.code == 7'h00) begin
                next_q.code = f;
                next_q.f47_arm = 1'b0;
            end
            next_q.stat[`PSF_IST_FAULT] = 1'b1;
            next_q.valve = 1'b0;
            next_q.lock = 1'b0;
            next_q.st = PSF_IDLE;
        end
        // read data captured in the setup phase
        if (psel && !penable) begin
            case (paddr)
                `PSF_REG_CFG: next_q.rdata = {8'h00, q.lim, 7'h00, q.top};
                `PSF_REG_FAULT: next_q.rdata = {q.st, 17'h00000,
                    q.f47_arm, (q.code != 7'h00), q.code};
                `PSF_REG_ISTAT: next_q.rdata = {30'h0, q.stat};
                `PSF_REG_IMASK: next_q.rdata = {30'h0, q.mask};
                default: next_q.rdata = 32'h00000000;
            endcase
        end
    end

    // ==========================================
    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.st <= PSF_IDLE;
            q.top <= `PSF_RST_TOP_ANG;
            q.lim <= `PSF_RST_LIM;
        end else begin
            q <= next_q;
        end
    end

    // ==========================================
    // outputs
    assign prdata = q.rdata;
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;
    assign valve_on = q.valve;
    assign lockout_on = q.lock;
    assign fault_active = (q.code != 7'h00);
    assign fault_code = q.code;
    assign irq = |(q.stat & q.mask);
endmodule : psf_monitor
`default_nettype wire

// *** psf_consts.svh ***
`ifndef PSF_CONSTS_SVH
`define PSF_CONSTS_SVH
// ==========================================
// timing
`define PSF_CLK_MHZ 200
`define PSF_SETTLE_US 10000
`define PSF_MS_US 1000
// ==========================================
// crank angles in degrees
`define PSF_DWELL_DEG 10'd20
`define PSF_MID_DEG 9'd180
`define PSF_WIN_BASE 10'd211
`define PSF_WIN_STEP 10'd30
`define PSF_WIN_SPAN 10'd29
// ==========================================
// fault codes
`define PSF_F47 7'h2f
`define PSF_F70 7'h46
`define PSF_F71 7'h47
`define PSF_F72 7'h48
`define PSF_F73 7'h49
`define PSF_F74 7'h4a
`define PSF_F75 7'h4b
`define PSF_F76 7'h4c
`define PSF_F77 7'h4d
`define PSF_F79 7'h4f
`define PSF_F81 7'h51
`define PSF_F85 7'h55
`define PSF_F88 7'h58
`define PSF_F89 7'h59
// ==========================================
// register offsets and fields
`define PSF_REG_CFG 12'h000
`define PSF_REG_FAULT 12'h004
`define PSF_REG_ISTAT 12'h008
`define PSF_REG_IMASK 12'h00c
`define PSF_CFG_LIM_LSB 16
`define PSF_RST_TOP_ANG 9'h11d
`define PSF_RST_LIM 8'hfa
`define PSF_IST_FAULT 0
`define PSF_IST_DONE 1
`endif

// *** psf_pkg.sv ***
package psf_pkg;
    // ==========================================
    // stroke sequencer states, one-hot
    typedef enum logic [5:0] {
        PSF_IDLE = 6'b000001,
        PSF_PRECHK = 6'b000010,
        PSF_LOCKON = 6'b000100,
        PSF_ENERGIZE = 6'b001000,
        PSF_RUN = 6'b010000,
        PSF_STOPCHK = 6'b100000
    } psf_state_t;
endpackage : psf_pkg

// *** psf_sync_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// raw pin bits in, synchronised bits out
interface psf_sync_if #(parameter int W = 8);
    logic [W-1:0] raw;
    logic [W-1:0] sync;
    modport sync_side (input raw, output sync);
    modport user (output raw, input sync);
endinterface : psf_sync_if
`default_nettype wire

// *** psf_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module psf_sync import psf_pkg::*; #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pins
    psf_sync_if.sync_side p
);
    // two stages, the first read only by the second
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } psf_sync_t;
    psf_sync_t q;
    psf_sync_t next_q;

    // ==========================================
    // stage shift
    always_comb begin
        next_q.s1 = p.raw;
        next_q.s2 = q.s1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign p.sync = q.s2;
endmodule : psf_sync
`default_nettype wire

// *** psf_monitor_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "psf_consts.svh"
// ==========================================
// port checker for the stroke fault monitor
module psf_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // operator and valve monitor pins
    input wire logic selector_off,
    input wire logic dual_safety_valve_ok,
    // outputs under watch
    input wire logic valve_on,
    input wire logic lockout_on,
    input wire logic fault_active,
    input wire logic [6:0] fault_code
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // a new fault must drop both drivers within one cycle
    fault_drop_a: assert property (
        $rose(fault_active) |-> ##[0:1] (!valve_on && !lockout_on))
        else $error("drivers stay on after a fault");
    no_restart_a: assert property (
        fault_active && !valve_on |=> !valve_on)
        else $error("valve rose while a fault was latched");
    first_kept_a: assert property (
        fault_active && $past(fault_active) |-> $stable(fault_code))
        else $error("latched fault code changed");
    code_flag_a: assert property (
        fault_active == (fault_code != 7'h00))
        else $error("fault flag and code disagree");
    code_known_a: assert property (
        fault_active |-> fault_code inside {`PSF_F47, [`PSF_F70:`PSF_F89]})
        else $error("fault code outside the known set");
    // two sync stages plus the latch, one spare cycle
    vmon_fault_a: assert property (
        !dual_safety_valve_ok [*4] |=> fault_active)
        else $error("valve monitor fault not latched");
    vmon_hold_a: assert property (
        fault_code == `PSF_F47 && !selector_off && !$past(selector_off)
        && !$past(selector_off, 2) |=> fault_code == `PSF_F47)
        else $error("valve monitor fault left without selector off");
    valve_lock_a: assert property (
        $rose(valve_on) |-> lockout_on && $past(lockout_on))
        else $error("valve energised without lockout relay");
    unmapped_a: assert property (
        psel && penable && paddr > 12'h00c |-> pslverr)
        else $error("unmapped access not refused");
    zero_wait_a: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
endmodule : psf_chk
bind psf_monitor psf_chk i_psf_chk (.clk, .rst, .psel, .penable, .paddr,
    .pready, .pslverr, .selector_off, .dual_safety_valve_ok, .valve_on,
    .lockout_on, .fault_active, .fault_code);
`default_nettype wire

// *** psf_plant.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// relays, resolver and overrun switch model
module psf_plant (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // commands from the monitor
    input wire logic valve_on,
    input wire logic lockout_on,
    // injected defect, 0 = healthy
    input wire logic [3:0] mode,
    // feedback
    output logic drv_a_fb,
    output logic drv_b_fb,
    output logic ctl_ff_fb,
    output logic mpd_window,
    output logic relay_a_closed,
    output logic relay_b_closed,
    output logic lock_drv_fb,
    output logic lock_check_closed,
    output logic overrun_sw,
    output logic [8:0] angle
);
    logic [1:0] tick; // paces resolver steps
    // feedback follows commands unless a defect is injected
    always_comb begin
        drv_a_fb = valve_on || mode == 4'd1;
        drv_b_fb = valve_on && mode != 4'd2;
        ctl_ff_fb = valve_on && mode != 4'd3;
        mpd_window = valve_on && mode != 4'd4;
        relay_a_closed = (valve_on || mode == 4'd6) && mode != 4'd5;
        relay_b_closed = relay_a_closed;
        lock_drv_fb = lockout_on && mode != 4'd7;
        // guided contacts read closed only while relay is off
        lock_check_closed = !lockout_on && mode != 4'd8;
        // one magnet at 20..39; a second one, a wrong spot or one
        // inside the top-stop dwell on demand
        overrun_sw = (mode == 4'd11) ? (angle >= 9'h0aa && angle < 9'h0be)
            : (angle >= 9'h014 && angle < 9'h028) ||
            (mode == 4'd10 && angle >= 9'h03c && angle < 9'h050) ||
            (mode == 4'd12 && angle >= 9'h11d && angle < 9'h131);
    end
    // 5 degrees per 4 cycles keeps angle steady past the synchroniser
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            angle <= 9'h000;
            tick <= 2'h0;
        end else if (valve_on && mode != 4'd9) begin
            tick <= tick + 2'h1;
            if (tick == 2'h3) begin
                angle <= (angle >= 9'h163) ? 9'h000 : angle + 9'h005;
            end
        end
    end
endmodule : psf_plant
`default_nettype wire

// *** press_stroke_fault_monitor_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "psf_consts.svh"
// ==========================================
// testbench top
module press_stroke_fault_monitor_tb;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic stroke_req, selector_off, reset_btn, dual_safety_valve_ok;
    logic drv_a_fb, drv_b_fb, ctl_ff_fb, mpd_window, relay_a_closed;
    logic relay_b_closed, lock_drv_fb, lock_check_closed, overrun_sw;
    logic [1:0] option_sw;
    logic [8:0] angle;
    logic valve_on, lockout_on, fault_active, irq;
    logic [6:0] fault_code;
    logic [3:0] mode; // defect injected in the plant
    int failures = 0;
    int samples_checked = 0;
    // expected code per plant defect
    logic [6:0] codes [1:12] = '{`PSF_F70, `PSF_F71, `PSF_F72, `PSF_F73,
        `PSF_F74, `PSF_F75, `PSF_F76, `PSF_F77, `PSF_F79, `PSF_F85, `PSF_F88,
        `PSF_F81};
    // long settle counts shortened for simulation
    psf_monitor #(.SETTLE_CYC(8), .MS_CYC(4)) i_psf_monitor (.clk, .rst,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .stroke_req, .selector_off, .reset_btn, .drv_a_fb,
        .drv_b_fb, .ctl_ff_fb, .mpd_window, .relay_a_closed,
        .relay_b_closed, .lock_drv_fb, .lock_check_closed,
        .dual_safety_valve_ok, .overrun_sw, .option_sw, .angle, .valve_on,
        .lockout_on, .fault_active, .fault_code, .irq);
    psf_plant i_psf_plant (.clk, .rst, .valve_on, .lockout_on, .mode,
        .drv_a_fb, .drv_b_fb, .ctl_ff_fb, .mpd_window, .relay_a_closed,
        .relay_b_closed, .lock_drv_fb, .lock_check_closed, .overrun_sw,
        .angle);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ==========================================
    // shared tasks
    task automatic chk(input logic [31:0] seen, exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %0t %s seen %h want %h", $time, what, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // request held until the valve opens, so no restart follows
    task automatic stroke();
        bit on;
        on = 1'b0;
        stroke_req <= 1'b1;
        for (int n = 0; n < 3000; n++) begin
            @(posedge clk);
            if (valve_on === 1'b1 && !on) begin
                on = 1'b1;
                stroke_req <= 1'b0;
            end
            if (fault_active === 1'b1 || (on && lockout_on === 1'b0)) break;
        end
        if (!on) stroke_req <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : stroke
    task automatic clr();
        reset_btn <= 1'b1;
        repeat (4) @(posedge clk);
        reset_btn <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : clr
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    // ==========================================
    // scenarios
    task automatic t_regs();
        apb(1'b0, `PSF_REG_CFG, 32'h0);
        chk(rd, {8'h00, `PSF_RST_LIM, 7'h00, `PSF_RST_TOP_ANG}, "cfg reset");
        apb(1'b1, `PSF_REG_FAULT, 32'hffffffff);
        apb(1'b0, `PSF_REG_FAULT, 32'h0);
        chk(rd, 32'h04000000, "fault reg read-only");
        apb(1'b0, 12'h010, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped refused");
        apb(1'b1, `PSF_REG_IMASK, 32'h1);
        apb(1'b0, `PSF_REG_IMASK, 32'h0);
        chk(rd, 32'h1, "mask readback");
    endtask : t_regs
    task automatic t_good();
        stroke();
        chk(fault_code, 32'h0, "clean stroke");
        apb(1'b0, `PSF_REG_ISTAT, 32'h0);
        chk(rd, 32'h2, "done flag");
        chk(irq, 32'h0, "done masked");
        apb(1'b1, `PSF_REG_ISTAT, 32'h2);
        apb(1'b0, `PSF_REG_ISTAT, 32'h0);
        chk(rd, 32'h0, "done cleared");
    endtask : t_good
    task automatic t_faults();
        for (int m = 1; m <= 12; m++) begin
            mode <= m[3:0];
            stroke();
            chk(fault_code, codes[m], "fault code");
            stroke_req <= 1'b1; // faults above to too
            repeat (20) @(posedge clk);
            chk(valve_on, 32'h0, "restart blocked");
            chk(lockout_on, 32'h0, "lockout dropped");
            chk(irq, 32'h1, "irq on fault");
            stroke_req <= 1'b0;
            apb(1'b1, `PSF_REG_ISTAT, 32'h3);
            repeat (2) @(posedge clk);
            chk(irq, 32'h0, "irq cleared");
            mode <= 4'd0;
            clr();
            chk(fault_code, 32'h0, "fault cleared");
        end
    endtask : t_faults
    task automatic t_switches();
        option_sw <= 2'd0;
        stroke();
        chk(fault_code, `PSF_F89, "window setting");
        option_sw <= 2'd2;
        clr();
        dual_safety_valve_ok <= 1'b0;
        repeat (8) @(posedge clk);
        chk(fault_code, `PSF_F47, "valve monitor");
        dual_safety_valve_ok <= 1'b1;
        clr();
        chk(fault_code, `PSF_F47, "needs selector off");
        selector_off <= 1'b1;
        repeat (6) @(posedge clk);
        chk(fault_code, 32'h0, "monitor fault cleared");
        selector_off <= 1'b0;
    endtask : t_switches
    // ==========================================
    // main sequence
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
        {stroke_req, selector_off, reset_btn, mode} = 7'h00;
        dual_safety_valve_ok = 1'b1;
        option_sw = 2'd2;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_good();
        t_faults();
        t_switches();
        tally_and_finish();
    end
    // hang guard, several times the expected run
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        $display("FAIL %0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule : press_stroke_fault_monitor_tb
`default_nettype wire
